/* File: hw/ssc_params.svh */
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// Register offsets on the plain register port
`define SSC_AW 4
`define SSC_REG_CTRL 4'h0
`define SSC_REG_XBUF 4'h1
`define SSC_REG_IST 4'h2
`define SSC_REG_IMSK 4'h3

// Control register fields and reset value
`define SSC_CTRL_RST 8'h00
`define SSC_B_WRITE_COLLISION_FLAG 7
`define SSC_B_OVF 6
`define SSC_B_EN 5
`define SSC_B_CKP 4
`define SSC_MODE_SLV_SS 4'h4
`define SSC_MODE_SLV_NOSS 4'h5

// Interrupt status and mask bits
`define SSC_NIRQ 3
`define SSC_I_RX 0
`define SSC_I_OVF 1
`define SSC_I_WRITE_COLLISION_FLAG 2

// Pin indices and synchroniser reset levels
`define SSC_NPIN 4
`define SSC_P_SCK 0
`define SSC_P_SDI 1
`define SSC_P_SDO 2
`define SSC_P_SS 3
`define SSC_PIN_IDLE 4'h8

// Master half periods in system clocks: clk/4, clk/16, clk/64
`define SSC_HALF_4 6'h02
`define SSC_HALF_16 6'h08
`define SSC_HALF_64 6'h20

`endif

/* File: hw/ssc_pkg.sv */
`default_nettype none
package ssc_pkg;
`include "ssc_params.svh"

   typedef logic [7:0] ssc_byte_t;
   typedef logic [3:0] ssc_mode_t;
   typedef enum logic {SSC_IDLE, SSC_SHIFT} ssc_eng_state_t;

   function automatic logic ssc_is_spi(input ssc_mode_t m);
      return m <= `SSC_MODE_SLV_NOSS;
   endfunction

   function automatic logic ssc_is_master(input ssc_mode_t m);
      return m[3:2] == 2'h0;
   endfunction

   // No timer source here, so the timer-clocked master runs at clk/64
   function automatic logic [5:0] ssc_half(input ssc_mode_t m);
      case (m[1:0])
         2'h0: return `SSC_HALF_4;
         2'h1: return `SSC_HALF_16;
         default: return `SSC_HALF_64;
      endcase
   endfunction
endpackage
`default_nettype wire

/* File: hw/ssc_shift_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ssc_shift_if;
   import ssc_pkg::*;
   logic en;
   logic master;
   logic ss_ctl;
   ssc_mode_t mode;
   logic sck_s;
   logic sdi_s;
   logic ss_n_s;
   logic start;
   ssc_byte_t tx;
   logic done;
   ssc_byte_t rx;
   logic busy;
   logic sck_o;
   logic sdo_o;
   modport ctl (output en, master, ss_ctl, mode, sck_s, sdi_s, ss_n_s, start, tx,
      input done, rx, busy, sck_o, sdo_o);
   modport eng (input en, master, ss_ctl, mode, sck_s, sdi_s, ss_n_s, start, tx,
      output done, rx, busy, sck_o, sdo_o);
endinterface
`default_nettype wire

/* File: hw/ssc_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module ssc_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Raw and filtered levels
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } ssc_sync_t;
   ssc_sync_t r_q, r_d;

   // A level counts only once stages two and three agree
   always_comb begin
      r_d = r_q;
      r_d.s1 = d_in;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      for (int i = 0; i < W; i++) begin
         if (r_q.s2[i] == r_q.s3[i]) begin
            r_d.q[i] = r_q.s3[i];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r_q <= '{INIT, INIT, INIT, INIT};
      end else begin
         r_q <= r_d;
      end
   end

   assign q_out = r_q.q;
endmodule
`default_nettype wire

/* File: hw/ssc_shift.sv */
`timescale 1ns/10ps
`default_nettype none
module ssc_shift (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Engine side of the shift link
   ssc_shift_if.eng sif
);
   import ssc_pkg::*;

   typedef struct packed {
      ssc_eng_state_t st;
      ssc_byte_t sr;
      logic [2:0] cnt;
      logic [5:0] div;
      logic sck_o;
      logic sdo_o;
      logic sck_p;
      logic done;
      ssc_byte_t rx;
   } ssc_eng_t;
   ssc_eng_t r_q, r_d;
   logic rise, fall;

   // Data sampled on the rising clock edge, driven on the falling edge
   always_comb begin
      r_d = r_q;
      r_d.done = 1'b0;
      r_d.sck_p = sif.sck_s;
      rise = sif.sck_s & ~r_q.sck_p;
      fall = ~sif.sck_s & r_q.sck_p;
      if (!sif.en) begin
         r_d = '0;
         r_d.sck_p = sif.sck_s;
      end else if (sif.master) begin
         case (r_q.st)
            SSC_IDLE: begin
               r_d.cnt = 3'h0;
               if (sif.start) begin
                  r_d.st = SSC_SHIFT;
                  r_d.sr = sif.tx;
                  r_d.sdo_o = sif.tx[7];
                  r_d.cnt = 3'h0;
                  r_d.div = ssc_half(sif.mode);
                  r_d.sck_o = 1'b0;
               end
            end
            SSC_SHIFT: begin
               r_d.div = r_q.div - 6'h01;
               if (r_q.div == 6'h01) begin
                  r_d.div = ssc_half(sif.mode);
                  r_d.sck_o = ~r_q.sck_o;
                  if (!r_q.sck_o) begin
                     r_d.sr = {r_q.sr[6:0], sif.sdi_s};
                  end else begin
                     r_d.cnt = r_q.cnt + 3'h1;
                     r_d.sdo_o = r_q.sr[7];
                     if (r_q.cnt == 3'h7) begin
                        r_d.st = SSC_IDLE;
                        r_d.done = 1'b1;
                        r_d.rx = r_q.sr;
                     end
                  end
               end
            end
            default: r_d.st = SSC_IDLE;
         endcase
      end else if (sif.ss_ctl && sif.ss_n_s) begin
         // Slave select going high mid-byte must not leave the engine looking busy
         r_d.st = SSC_IDLE;
         r_d.cnt = 3'h0;
      end else begin
         r_d.st = SSC_IDLE;
         if (sif.start) begin
            r_d.sr = sif.tx;
            r_d.sdo_o = sif.tx[7];
         end
         if (rise) begin
            r_d.sr = {r_q.sr[6:0], sif.sdi_s};
            r_d.cnt = r_q.cnt + 3'h1;
            if (r_q.cnt == 3'h7) begin
               r_d.done = 1'b1;
               r_d.rx = {r_q.sr[6:0], sif.sdi_s};
            end
         end else if (fall) begin
            r_d.sdo_o = r_q.sr[7];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign sif.done = r_q.done;
   assign sif.rx = r_q.rx;
   assign sif.busy = (r_q.st == SSC_SHIFT) || (r_q.cnt != 3'h0);
   assign sif.sck_o = r_q.sck_o;
   assign sif.sdo_o = r_q.sdo_o;

   a_ss_release: assert property (@(posedge clk_in) disable iff (srst_in)
      (sif.en && !sif.master && sif.ss_ctl && sif.ss_n_s) |=> !sif.busy)
      else $error("Slave select high did not idle the slave");
endmodule
`default_nettype wire

/* File: hw/ssc_ctrl.sv */
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ssc_params.svh"
module ssc_ctrl (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Register port
   input wire logic [3:0] addr_in,
   input wire ssc_pkg::ssc_byte_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output ssc_pkg::ssc_byte_t rdata_out,
   // Serial pins: 0 clock, 1 data in, 2 data out, 3 slave select
   input wire logic [3:0] pin_in,
   output logic [3:0] pin_do_out,
   output logic [3:0] pin_oe_out,
   output logic [3:0] pin_fn_out,
   // General-purpose port drive for the same pins
   input wire logic [3:0] gpio_do_in,
   input wire logic [3:0] gpio_oe_in,
   // Interrupt
   output logic irq_out
);
   import ssc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      ssc_byte_t ctrl;
      ssc_byte_t xbuf;
      logic full;
      logic [2:0] ist;
      logic [2:0] imsk;
      ssc_byte_t rdata;
      logic irq;
      logic [3:0] pdo;
      logic [3:0] poe;
      logic [3:0] pfn;
      logic start;
      ssc_byte_t tx;
   } ssc_top_t;
   ssc_top_t r_q, r_d;

   ssc_shift_if sif();
   logic [3:0] pin_s;
   logic en_w, spi_w, mst_w, slave_w, ssctl_w;
   logic wr_ctrl, wr_xbuf, rd_xbuf, wr_ist, wr_imsk;
   logic ovf_ev, write_collision_flag_ev, rx_ev;
   logic [3:0] sdo_v, soe_v, sfn_v;

   ////////////////////////////////////////////////////////////////////////////
   ssc_sync #(
      .W(`SSC_NPIN),
      .INIT(`SSC_PIN_IDLE)
   ) u_sync (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .d_in(pin_in),
      .q_out(pin_s)
   );

   ssc_shift u_shift (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .sif(sif)
   );

   assign sif.en = en_w;
   assign sif.master = mst_w;
   assign sif.ss_ctl = ssctl_w;
   assign sif.mode = r_q.ctrl[3:0];
   assign sif.sck_s = pin_s[`SSC_P_SCK];
   assign sif.sdi_s = pin_s[`SSC_P_SDI];
   assign sif.ss_n_s = pin_s[`SSC_P_SS];
   assign sif.start = r_q.start;
   assign sif.tx = r_q.tx;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      r_d = r_q;
      r_d.start = 1'b0;
      r_d.rdata = 8'h00;
      en_w = r_q.ctrl[`SSC_B_EN];
      spi_w = ssc_is_spi(r_q.ctrl[3:0]);
      mst_w = spi_w && ssc_is_master(r_q.ctrl[3:0]);
      slave_w = spi_w && !mst_w;
      ssctl_w = r_q.ctrl[3:0] == `SSC_MODE_SLV_SS;
      wr_ctrl = wr_in && (addr_in == `SSC_REG_CTRL);
      wr_xbuf = wr_in && (addr_in == `SSC_REG_XBUF);
      rd_xbuf = rd_in && (addr_in == `SSC_REG_XBUF);
      wr_ist = wr_in && (addr_in == `SSC_REG_IST);
      wr_imsk = wr_in && (addr_in == `SSC_REG_IMSK);

      // Only a slave can be overrun; a master paces itself by buffer writes
      ovf_ev = en_w && slave_w && sif.done && r_q.full;
      rx_ev = en_w && sif.done && !ovf_ev;
      write_collision_flag_ev = en_w && wr_xbuf && (sif.busy || r_q.start);

      if (wr_ctrl) begin
         r_d.ctrl = wdata_in;
      end
      // Hardware set wins over a software clear in the same cycle
      if (write_collision_flag_ev) begin
         r_d.ctrl[`SSC_B_WRITE_COLLISION_FLAG] = 1'b1;
      end
      if (ovf_ev) begin
         r_d.ctrl[`SSC_B_OVF] = 1'b1;
      end

      if (rd_xbuf) begin
         r_d.full = 1'b0;
      end
      if (rx_ev) begin
         r_d.xbuf = sif.rx;
         r_d.full = 1'b1;
      end
      // A colliding write is dropped so the byte in flight stays intact; a pending launch counts as busy
      if (en_w && wr_xbuf && !write_collision_flag_ev) begin
         r_d.start = 1'b1;
         r_d.tx = wdata_in;
      end

      if (wr_ist) begin
         r_d.ist = r_q.ist & ~wdata_in[2:0];
      end
      r_d.ist[`SSC_I_RX] = r_d.ist[`SSC_I_RX] | rx_ev;
      r_d.ist[`SSC_I_OVF] = r_d.ist[`SSC_I_OVF] | ovf_ev;
      r_d.ist[`SSC_I_WRITE_COLLISION_FLAG] = r_d.ist[`SSC_I_WRITE_COLLISION_FLAG] | write_collision_flag_ev;
      if (wr_imsk) begin
         r_d.imsk = wdata_in[2:0];
      end
      r_d.irq = |(r_d.ist & r_d.imsk);

      if (rd_in) begin
         case (addr_in)
            `SSC_REG_CTRL: r_d.rdata = r_q.ctrl;
            `SSC_REG_XBUF: r_d.rdata = r_q.xbuf;
            `SSC_REG_IST: r_d.rdata = {5'h00, r_q.ist};
            `SSC_REG_IMSK: r_d.rdata = {5'h00, r_q.imsk};
            default: r_d.rdata = 8'h00;
         endcase
      end

      // Two-wire datapath is not built here, so its lines stay released
      sfn_v = 4'h0;
      sdo_v = 4'h0;
      soe_v = 4'h0;
      if (en_w && spi_w) begin
         sfn_v = 4'h7;
         sfn_v[`SSC_P_SS] = ssctl_w;
         sdo_v[`SSC_P_SCK] = sif.sck_o;
         soe_v[`SSC_P_SCK] = mst_w;
         sdo_v[`SSC_P_SDO] = sif.sdo_o;
         soe_v[`SSC_P_SDO] = !(ssctl_w && pin_s[`SSC_P_SS]);
      end else if (en_w) begin
         sfn_v = 4'h3;
      end
      for (int i = 0; i < `SSC_NPIN; i++) begin
         r_d.pfn[i] = sfn_v[i];
         r_d.pdo[i] = sfn_v[i] ? sdo_v[i] : gpio_do_in[i];
         r_d.poe[i] = sfn_v[i] ? soe_v[i] : gpio_oe_in[i];
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r_q <= '0;
         r_q.ctrl <= `SSC_CTRL_RST;
      end else begin
         r_q <= r_d;
      end
   end

   assign rdata_out = r_q.rdata;
   assign pin_do_out = r_q.pdo;
   assign pin_oe_out = r_q.poe;
   assign pin_fn_out = r_q.pfn;
   assign irq_out = r_q.irq;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   sequence s_overrun;
      en_w && slave_w && sif.done && r_q.full;
   endsequence

   sequence s_collide;
      en_w && wr_xbuf && (sif.busy || r_q.start);
   endsequence

   a_ovf_flag_set: assert property (s_overrun |=> r_q.ctrl[`SSC_B_OVF])
      else $error("Overrun did not set the overflow flag");

   a_ovf_buf_keep: assert property (s_overrun |=> $stable(r_q.xbuf) && r_q.ist[`SSC_I_OVF])
      else $error("Overrun changed the buffered byte");

   a_ovf_slave_only: assert property (
      ($rose(r_q.ctrl[`SSC_B_OVF]) && !$past(wr_ctrl)) |-> $past(en_w && slave_w))
      else $error("Overflow raised outside slave mode");

   a_ovf_no_master: assert property (
      (en_w && mst_w && !wr_ctrl && !r_q.ctrl[`SSC_B_OVF]) |=> !r_q.ctrl[`SSC_B_OVF])
      else $error("Overflow raised in master mode");

   a_spi_pin_take: assert property (
      (en_w && spi_w) |=> (pin_fn_out[2:0] == 3'h7) && (pin_oe_out[`SSC_P_SDI] == 1'b0)
      && (pin_oe_out[`SSC_P_SCK] == $past(mst_w)))
      else $error("Serial pins not handed over in SPI mode");

   a_twi_pin_take: assert property (
      (en_w && !spi_w) |=> (pin_fn_out == 4'h3) && (pin_oe_out[1:0] == 2'h0)
      && (pin_oe_out[3:2] == $past(gpio_oe_in[3:2])))
      else $error("Two-wire pins not handed over");

   a_gpio_return: assert property (
      !en_w |=> (pin_fn_out == 4'h0) && (pin_do_out == $past(gpio_do_in))
      && (pin_oe_out == $past(gpio_oe_in)))
      else $error("Disabled port kept its pins");

   a_write_collision_flag_set: assert property (s_collide |=> r_q.ctrl[`SSC_B_WRITE_COLLISION_FLAG] && !r_q.start)
      else $error("Collision not flagged or write not dropped");

   a_write_collision_flag_hold: assert property (
      (r_q.ctrl[`SSC_B_WRITE_COLLISION_FLAG] && !(wr_ctrl && !wdata_in[`SSC_B_WRITE_COLLISION_FLAG])) |=> r_q.ctrl[`SSC_B_WRITE_COLLISION_FLAG])
      else $error("Collision flag cleared without a write");

   a_irq_level: assert property (
      ((r_q.ist & r_q.imsk) != 3'h0) && !wr_ist && !wr_imsk |=> irq_out)
      else $error("Interrupt low with unmasked status");

   a_irq_quiet: assert property (
      (((r_q.ist & r_q.imsk) == 3'h0) && !wr_imsk && !rx_ev && !ovf_ev && !write_collision_flag_ev) |=> !irq_out)
      else $error("Interrupt high with nothing unmasked");

   ////////////////////////////////////////////////////////////////////////////
   sequence s_byte_in;
      en_w && sif.done && !r_q.full;
   endsequence

   sequence s_launch;
      r_q.start ##1 sif.busy;
   endsequence

   a_rx_buf_load: assert property (s_byte_in |=> r_q.full && (r_q.xbuf == $past(sif.rx)))
      else $error("Received byte not loaded into the buffer");

   a_rx_status_set: assert property (s_byte_in |=> r_q.ist[`SSC_I_RX])
      else $error("Received byte did not raise its status bit");

   a_buf_read_clear: assert property ((rd_xbuf && !sif.done) |=> !r_q.full)
      else $error("Buffer read did not free the buffer");

   a_ovf_sticky: assert property ((r_q.ctrl[`SSC_B_OVF] && !wr_ctrl) |=> r_q.ctrl[`SSC_B_OVF])
      else $error("Overflow flag cleared without a write");

   a_ovf_needs_full: assert property (
      ($rose(r_q.ctrl[`SSC_B_OVF]) && !$past(wr_ctrl)) |-> $past(sif.done && r_q.full))
      else $error("Overflow raised with the buffer free");

   a_write_collision_flag_drop: assert property (s_collide |=> $stable(r_q.tx))
      else $error("Colliding write reached the shifter");

   a_write_collision_flag_cause: assert property (
      ($rose(r_q.ctrl[`SSC_B_WRITE_COLLISION_FLAG]) && !$past(wr_ctrl)) |-> $past(wr_xbuf && (sif.busy || r_q.start)))
      else $error("Collision raised without a busy buffer write");

   a_rdata_idle: assert property (!rd_in |=> (rdata_out == 8'h00))
      else $error("Read data not zero outside a read");

   a_rdata_ctrl: assert property (
      (rd_in && (addr_in == `SSC_REG_CTRL)) |=> (rdata_out == $past(r_q.ctrl)))
      else $error("Control read returned a wrong value");

   a_sdo_release: assert property (
      (en_w && ssctl_w && pin_s[`SSC_P_SS]) |=> !pin_oe_out[`SSC_P_SDO])
      else $error("Deselected slave kept driving data out");

   a_sdo_drive: assert property (
      (en_w && spi_w && !ssctl_w) |=> pin_oe_out[`SSC_P_SDO] && pin_fn_out[`SSC_P_SDO])
      else $error("Data out not driven by the port");

   a_ss_fn: assert property (
      (en_w && spi_w) |=> (pin_fn_out[`SSC_P_SS] == $past(ssctl_w)))
      else $error("Slave select ownership wrong for the mode");

   a_sck_follow: assert property (
      (en_w && mst_w) |=> pin_oe_out[`SSC_P_SCK] && (pin_do_out[`SSC_P_SCK] == $past(sif.sck_o)))
      else $error("Master clock not driven on its pin");

   a_master_launch: assert property (
      (en_w && mst_w && wr_xbuf && !sif.busy && !r_q.start) |=> s_launch)
      else $error("Buffer write did not start the master");

   a_master_idle: assert property (
      (en_w && mst_w && !sif.busy && !r_q.start) |=> !sif.busy)
      else $error("Master started without a buffer write");
endmodule
`default_nettype wire

/* File: verification/ssc_peer.sv */
`timescale 1ns/10ps
`default_nettype none
module ssc_peer (
   // Pins towards the port
   output logic sck_out,
   output logic sdi_out,
   output logic ss_n_out
);
   initial begin
      sck_out = 1'b0;
      sdi_out = 1'b0;
      ss_n_out = 1'b1;
   end

   ////////////////////////////////////////////////////////////////
   // One byte, MSB first; clock stands low outside frames
   task automatic xfer(input logic [7:0] b);
      ss_n_out = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         sdi_out = b[i];
         #400 sck_out = 1'b1;
         #400 sck_out = 1'b0;
      end
      #400 ss_n_out = 1'b1;
      // Released line must not look like held data
      sdi_out = ~sdi_out;
   endtask
endmodule
`default_nettype wire

/* File: verification/tb_sync_serial_port_control.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_sync_serial_port_control;
   import ssc_pkg::*;
   logic clk_in;
   logic srst_in;
   logic [3:0] addr_in;
   ssc_byte_t wdata_in;
   logic wr_in;
   logic rd_in;
   ssc_byte_t rdata_out;
   logic [3:0] pin_in;
   logic [3:0] pin_do_out;
   logic [3:0] pin_oe_out;
   logic [3:0] pin_fn_out;
   logic [3:0] gpio_do_in;
   logic [3:0] gpio_oe_in;
   logic irq_out;
   logic p_sck;
   logic p_sdi;
   logic p_ss_n;
   int miscompares;
   int total_checks;

   ssc_ctrl u_dut (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(pin_in), .pin_do_out(pin_do_out),
      .pin_oe_out(pin_oe_out), .pin_fn_out(pin_fn_out), .gpio_do_in(gpio_do_in),
      .gpio_oe_in(gpio_oe_in), .irq_out(irq_out));
   ssc_peer u_peer (.sck_out(p_sck), .sdi_out(p_sdi), .ss_n_out(p_ss_n));

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // Wire levels; an undriven data-out line toggles instead of holding
   always @(posedge clk_in) begin
      pin_in[0] <= pin_oe_out[0] ? pin_do_out[0] : p_sck;
      pin_in[1] <= p_sdi;
      pin_in[2] <= pin_oe_out[2] ? pin_do_out[2] : ~pin_in[2];
      pin_in[3] <= p_ss_n;
   end

   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, exp, what);
   endtask

   task automatic pins_chk(input logic [7:0] exp, input string what);
      repeat (3) @(posedge clk_in);
      #1 chk({4'h0, pin_fn_out}, exp, what);
   endtask

   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge clk_in);
      #1 chk({7'h0, irq_out}, {7'h0, exp}, "irq");
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   // Whole run is about 700 cycles
   initial begin
      #500000;
      miscompares++;
      print_verdict();
   end

   initial begin
      srst_in = 1'b1;
      addr_in = 4'h0;
      wdata_in = 8'h00;
      wr_in = 1'b0;
      rd_in = 1'b0;
      pin_in = 4'h8;
      gpio_do_in = 4'hA;
      gpio_oe_in = 4'h5;
      miscompares = 0;
      total_checks = 0;
      repeat (8) @(posedge clk_in);
      srst_in <= 1'b0;
      rd_chk(4'h0, 8'h00, "ctrl reset");
      wr(4'h7, 8'hFF);
      rd_chk(4'h7, 8'h00, "unmapped");
      pins_chk(8'h00, "fn off");
      chk({pin_oe_out, pin_do_out}, 8'h5A, "gpio pass");
      $display("test reset done");

      wr(4'h3, 8'h02);
      wr(4'h0, 8'h24);
      pins_chk(8'h0F, "fn slave");
      chk({7'h0, pin_oe_out[2]}, 8'h00, "sdo released");
      u_peer.xfer(8'hA5);
      repeat (8) @(posedge clk_in);
      rd_chk(4'h2, 8'h01, "rx status");
      rd_chk(4'h1, 8'hA5, "rx byte");
      rd_chk(4'h0, 8'h24, "no ovf");
      u_peer.xfer(8'h3C);
      u_peer.xfer(8'hC3);
      repeat (8) @(posedge clk_in);
      rd_chk(4'h0, 8'h64, "ovf flag");
      rd_chk(4'h2, 8'h03, "ovf status");
      irq_chk(1'b1);
      wr(4'h3, 8'h00);
      irq_chk(1'b0);
      wr(4'h3, 8'h02);
      irq_chk(1'b1);
      rd_chk(4'h1, 8'h3C, "byte kept");
      wr(4'h2, 8'h07);
      irq_chk(1'b0);
      $display("test slave done");

      wr(4'h0, 8'h20);
      wr(4'h1, 8'h5A);
      wr(4'h1, 8'h11);
      #1 chk({7'h0, pin_oe_out[0]}, 8'h01, "sck driven");
      repeat (60) @(posedge clk_in);
      rd_chk(4'h0, 8'hA0, "collision");
      rd_chk(4'h2, 8'h05, "coll status");
      wr(4'h0, 8'h20);
      wr(4'h1, 8'h22);
      repeat (60) @(posedge clk_in);
      wr(4'h1, 8'h33);
      repeat (60) @(posedge clk_in);
      rd_chk(4'h0, 8'h20, "master no ovf");
      rd_chk(4'h1, 8'h00, "master rx");
      $display("test master done");

      wr(4'h0, 8'h26);
      pins_chk(8'h03, "fn two-wire");
      wr(4'h0, 8'h06);
      pins_chk(8'h00, "fn disabled");
      chk({pin_oe_out, pin_do_out}, 8'h5A, "gpio back");
      $display("test modes done");
      print_verdict();
   end
endmodule
`default_nettype wire
